// ===== bbcd_defs.svh
// Purpose: Constants for the branch, bit and control decoder of the 8-bit core.
// Assumes: One core clock; opcode bytes arrive whole from the fetch unit.
// Notes:   Opcode layouts, cycle counts and byte lengths are named here.
`ifndef BBCD_DEFS_SVH
`define BBCD_DEFS_SVH

// Field positions inside the opcode byte.
`define BBCD_SPAN_HI      7
`define BBCD_SPAN_LO      4
`define BBCD_DIR_BIT      3
`define BBCD_TEST_HI      2
`define BBCD_TEST_LO      1
`define BBCD_SHORT_BIT    0
`define BBCD_POL_BIT      4
`define BBCD_TGT_HI       7
`define BBCD_TGT_LO       4
`define BBCD_LOW_HI       3
`define BBCD_LOW_LO       0
`define BBCD_IDX2_BIT     5
`define BBCD_IDX1_BIT     6
`define BBCD_IDX0_BIT     7

// Low-nibble class codes.
`define BBCD_LOW_CALL     4'h1
`define BBCD_LOW_JUMP     4'h9
`define BBCD_LOW_BTEST    4'h3
`define BBCD_LOW_BMOD     4'hB
`define BBCD_LOW_CTRL     4'hD

// Short-branch test codes.
`define BBCD_TEST_NZ      2'h0
`define BBCD_TEST_NC      2'h1
`define BBCD_TEST_Z       2'h2
`define BBCD_TEST_C       2'h3

// Full control opcodes.
`define BBCD_OP_NOP       8'h0D
`define BBCD_OP_HALT      8'h6D
`define BBCD_OP_SRET      8'hCD
`define BBCD_OP_IRET      8'hDD
`define BBCD_OP_IDLE      8'hED

// Cycle counts, loaded as count minus one.
`define BBCD_CYC_SHORT    3'h1
`define BBCD_CYC_BTEST    3'h4
`define BBCD_CYC_BMOD     3'h3
`define BBCD_CYC_LONG     3'h3
`define BBCD_CYC_CTRL     3'h1
`define BBCD_CYC_OTHER    3'h1
`define BBCD_CNT_LAST     3'h1
`define BBCD_CNT_STEP     3'h1

// Program counter steps (instruction lengths and relative bases).
`define BBCD_PC_STEP1     12'h001
`define BBCD_PC_STEP2     12'h002
`define BBCD_PC_STEP3     12'h003
`define BBCD_PC_RESET     12'h000

// Return stack.
`define BBCD_STK_AW       3
`define BBCD_STK_DEPTH    8
`define BBCD_SP_RESET     3'h0
`define BBCD_SP_STEP      3'h1

`define BBCD_BYTE_ZERO    8'h00
`define BBCD_SPAN_PAD     8'h00

`endif

// ===== bbcd_pkg.sv
// Purpose: Types shared by the decoder files.
// Assumes: Constants come from bbcd_defs.svh.
// Notes:   Types only.
package bbcd_pkg;

    typedef enum logic {
        BBCD_IDLE,
        BBCD_EXEC
    } bbcd_state_e;

    typedef enum logic [3:0] {
        BBCD_C_SHORT,
        BBCD_C_BTEST,
        BBCD_C_BMOD,
        BBCD_C_CALL,
        BBCD_C_JUMP,
        BBCD_C_NOP,
        BBCD_C_SRET,
        BBCD_C_IRET,
        BBCD_C_HALT,
        BBCD_C_IDLE,
        BBCD_C_FOREIGN
    } bbcd_class_e;

endpackage : bbcd_pkg

// ===== bbcd_stack.sv
// Purpose: Return-address memory for the call and return instructions.
// Assumes: One write port, one read port, read data registered.
// Notes:   Overflow wraps and overwrites the oldest entry.
`timescale 1ns/100ps
`include "bbcd_defs.svh"
module bbcd_stack (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    // Write port
    input  wire logic                     wr_en,
    input  wire logic [`BBCD_STK_AW-1:0]  wr_addr,
    input  wire logic [11:0]              wr_data,
    // Read port
    input  wire logic [`BBCD_STK_AW-1:0]  rd_addr,
    output logic      [11:0]              rd_data_ff
);
    logic [11:0] mem_ff [`BBCD_STK_DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_ff <= `BBCD_PC_RESET;
        end else begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end
endmodule : bbcd_stack

// ===== bbcd_decoder.sv
// Purpose: Decode and execute branches, bit operations, jumps, calls and control ops.
// Assumes: Fetch hands over one whole instruction (opcode plus operand bytes) per issue.
// Notes:   Data space answers a read one cycle after the read strobe.
`timescale 1ns/100ps
`include "bbcd_defs.svh"
module bbcd_decoder (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [7:0]  instr_opcode,
    input  wire logic [7:0]  instr_byte2,
    input  wire logic [7:0]  instr_byte3,
    input  wire logic [11:0] instr_pc,
    output logic             busy,
    output logic             done,
    output logic             foreign_op,
    // Program counter
    output logic             branch_taken,
    output logic [11:0]      pc_target,
    // Flags and options
    input  wire logic        flag_z,
    input  wire logic        flag_c,
    input  wire logic        saved_z,
    input  wire logic        saved_c,
    input  wire logic        wdg_sel,
    output logic             flag_we_z,
    output logic             flag_we_c,
    output logic             flag_z_new,
    output logic             flag_c_new,
    // Data space
    output logic             ds_rd_en,
    output logic             ds_wr_en,
    output logic [7:0]       ds_addr,
    output logic [7:0]       ds_wr_data,
    input  wire logic [7:0]  ds_rd_data,
    // Power and interrupt control
    output logic             halt_req,
    output logic             idle_req,
    output logic             int_return
);

    // Classify an opcode byte.
    function automatic bbcd_pkg::bbcd_class_e class_of(input logic [7:0] op);
        bbcd_pkg::bbcd_class_e c;
        c = bbcd_pkg::BBCD_C_FOREIGN;
        if (op[`BBCD_SHORT_BIT] == 1'b0) begin
            c = bbcd_pkg::BBCD_C_SHORT;
        end else if (op[`BBCD_LOW_HI:`BBCD_LOW_LO] == `BBCD_LOW_CALL) begin
            c = bbcd_pkg::BBCD_C_CALL;
        end else if (op[`BBCD_LOW_HI:`BBCD_LOW_LO] == `BBCD_LOW_JUMP) begin
            c = bbcd_pkg::BBCD_C_JUMP;
        end else if (op[`BBCD_LOW_HI:`BBCD_LOW_LO] == `BBCD_LOW_BTEST) begin
            c = bbcd_pkg::BBCD_C_BTEST;
        end else if (op[`BBCD_LOW_HI:`BBCD_LOW_LO] == `BBCD_LOW_BMOD) begin
            c = bbcd_pkg::BBCD_C_BMOD;
        end else if (op == `BBCD_OP_NOP) begin
            c = bbcd_pkg::BBCD_C_NOP;
        end else if (op == `BBCD_OP_SRET) begin
            c = bbcd_pkg::BBCD_C_SRET;
        end else if (op == `BBCD_OP_IRET) begin
            c = bbcd_pkg::BBCD_C_IRET;
        end else if (op == `BBCD_OP_HALT) begin
            c = bbcd_pkg::BBCD_C_HALT;
        end else if (op == `BBCD_OP_IDLE) begin
            c = bbcd_pkg::BBCD_C_IDLE;
        end
        return c;
    endfunction : class_of

    // Cycle count of a class, minus one.
    function automatic logic [2:0] cycles_of(input bbcd_pkg::bbcd_class_e c);
        logic [2:0] n;
        n = `BBCD_CYC_OTHER;
        case (c)
            bbcd_pkg::BBCD_C_SHORT: n = `BBCD_CYC_SHORT;
            bbcd_pkg::BBCD_C_BTEST: n = `BBCD_CYC_BTEST;
            bbcd_pkg::BBCD_C_BMOD:  n = `BBCD_CYC_BMOD;
            bbcd_pkg::BBCD_C_CALL,
            bbcd_pkg::BBCD_C_JUMP:  n = `BBCD_CYC_LONG;
            default:                n = `BBCD_CYC_CTRL;
        endcase
        return n;
    endfunction : cycles_of

    // Short relative target: forward adds span plus one, backward subtracts span.
    function automatic logic [11:0] short_target(input logic [11:0] pc,
                                                 input logic [7:0]  op);
        logic [11:0] span;
        span = {`BBCD_SPAN_PAD, op[`BBCD_SPAN_HI:`BBCD_SPAN_LO]};
        if (op[`BBCD_DIR_BIT]) begin
            return pc - span;
        end
        return pc + `BBCD_PC_STEP1 + span;
    endfunction : short_target

    // Bit index of bit-test and bit set/clear opcodes.
    function automatic logic [2:0] bit_index(input logic [7:0] op);
        return {op[`BBCD_IDX2_BIT], op[`BBCD_IDX1_BIT], op[`BBCD_IDX0_BIT]};
    endfunction : bit_index

    bbcd_pkg::bbcd_state_e         state_ff, nxt_state;
    bbcd_pkg::bbcd_class_e         cls_ff, nxt_cls;
    logic [2:0]                    cnt_ff, nxt_cnt;
    logic [7:0]                    op_ff, nxt_op;
    logic [7:0]                    b2_ff, nxt_b2;
    logic [7:0]                    b3_ff, nxt_b3;
    logic [11:0]                   pc_ff, nxt_pc;
    logic [7:0]                    data_ff, nxt_data;
    logic                          rd_wait_ff, nxt_rd_wait;
    logic [`BBCD_STK_AW-1:0]       sp_ff, nxt_sp;
    logic                          busy_ff, nxt_busy;
    logic                          done_ff, nxt_done;
    logic                          foreign_ff, nxt_foreign;
    logic                          taken_ff, nxt_taken;
    logic [11:0]                   tgt_ff, nxt_tgt;
    logic                          we_z_ff, nxt_we_z;
    logic                          we_c_ff, nxt_we_c;
    logic                          z_new_ff, nxt_z_new;
    logic                          c_new_ff, nxt_c_new;
    logic                          rd_en_ff, nxt_rd_en;
    logic                          wr_en_ff, nxt_wr_en;
    logic [7:0]                    addr_ff, nxt_addr;
    logic [7:0]                    wdata_ff, nxt_wdata;
    logic                          halt_ff, nxt_halt;
    logic                          idle_ff, nxt_idle;
    logic                          iret_ff, nxt_iret;
    logic                          stk_we;
    logic [11:0]                   stk_wdata;
    logic [`BBCD_STK_AW-1:0]       stk_raddr;
    logic [11:0]                   stk_rdata;
    bbcd_pkg::bbcd_class_e         in_cls;
    logic                          tested_bit;
    logic                          cond_ok;

    assign in_cls     = class_of(instr_opcode);
    assign tested_bit = data_ff[bit_index(op_ff)];
    assign stk_raddr  = sp_ff - `BBCD_SP_STEP;

    // Return stack write happens in the issue cycle of a call.
    assign stk_we    = (state_ff == bbcd_pkg::BBCD_IDLE) && instr_valid
                       && (in_cls == bbcd_pkg::BBCD_C_CALL);
    assign stk_wdata = instr_pc + `BBCD_PC_STEP2;

    bbcd_stack u_stack (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .wr_en      (stk_we),
        .wr_addr    (sp_ff),
        .wr_data    (stk_wdata),
        .rd_addr    (stk_raddr),
        .rd_data_ff (stk_rdata)
    );

    // Condition of a short branch, sampled from the live flags at completion.
    always_comb begin
        cond_ok = 1'b0;
        case (op_ff[`BBCD_TEST_HI:`BBCD_TEST_LO])
            `BBCD_TEST_NZ: cond_ok = !flag_z;
            `BBCD_TEST_Z:  cond_ok = flag_z;
            `BBCD_TEST_NC: cond_ok = !flag_c;
            default:       cond_ok = flag_c;
        endcase
    end

    always_comb begin
        nxt_state   = state_ff;
        nxt_cls     = cls_ff;
        nxt_cnt     = cnt_ff;
        nxt_op      = op_ff;
        nxt_b2      = b2_ff;
        nxt_b3      = b3_ff;
        nxt_pc      = pc_ff;
        nxt_data    = data_ff;
        nxt_rd_wait = rd_en_ff;
        nxt_sp      = sp_ff;
        nxt_busy    = busy_ff;
        nxt_tgt     = tgt_ff;
        nxt_z_new   = z_new_ff;
        nxt_c_new   = c_new_ff;
        nxt_addr    = addr_ff;
        nxt_wdata   = wdata_ff;
        nxt_done    = 1'b0;
        nxt_foreign = 1'b0;
        nxt_taken   = 1'b0;
        nxt_we_z    = 1'b0;
        nxt_we_c    = 1'b0;
        nxt_rd_en   = 1'b0;
        nxt_wr_en   = 1'b0;
        nxt_halt    = 1'b0;
        nxt_idle    = 1'b0;
        nxt_iret    = 1'b0;
        // Read data arrives one cycle after the strobe.
        if (rd_wait_ff) begin
            nxt_data = ds_rd_data;
        end
        case (state_ff)
            bbcd_pkg::BBCD_IDLE: begin
                if (instr_valid) begin
                    nxt_state = bbcd_pkg::BBCD_EXEC;
                    nxt_busy  = 1'b1;
                    nxt_cls   = in_cls;
                    nxt_cnt   = cycles_of(in_cls);
                    nxt_op    = instr_opcode;
                    nxt_b2    = instr_byte2;
                    nxt_b3    = instr_byte3;
                    nxt_pc    = instr_pc;
                    if ((in_cls == bbcd_pkg::BBCD_C_BTEST)
                        || (in_cls == bbcd_pkg::BBCD_C_BMOD)) begin
                        nxt_rd_en = 1'b1;
                        nxt_addr  = instr_byte2;
                    end
                    if (in_cls == bbcd_pkg::BBCD_C_CALL) begin
                        nxt_sp = sp_ff + `BBCD_SP_STEP;
                    end
                end
            end
            default: begin
                nxt_cnt = cnt_ff - `BBCD_CNT_STEP;
                if (cnt_ff == `BBCD_CNT_LAST) begin
                    nxt_state = bbcd_pkg::BBCD_IDLE;
                    nxt_busy  = 1'b0;
                    nxt_done  = 1'b1;
                    nxt_tgt   = pc_ff + `BBCD_PC_STEP1;
                    case (cls_ff)
                        bbcd_pkg::BBCD_C_SHORT: begin
                            if (cond_ok) begin
                                nxt_taken = 1'b1;
                                nxt_tgt   = short_target(pc_ff, op_ff);
                            end
                        end
                        bbcd_pkg::BBCD_C_BTEST: begin
                            nxt_we_c  = 1'b1;
                            nxt_c_new = tested_bit;
                            nxt_tgt   = pc_ff + `BBCD_PC_STEP3;
                            if (tested_bit == op_ff[`BBCD_POL_BIT]) begin
                                nxt_taken = 1'b1;
                                nxt_tgt   = pc_ff + `BBCD_PC_STEP2
                                            + 12'($signed(b3_ff));
                            end
                        end
                        bbcd_pkg::BBCD_C_BMOD: begin
                            nxt_wr_en = 1'b1;
                            nxt_wdata = data_ff;
                            nxt_wdata[bit_index(op_ff)] = op_ff[`BBCD_POL_BIT];
                            nxt_tgt   = pc_ff + `BBCD_PC_STEP2;
                        end
                        bbcd_pkg::BBCD_C_CALL,
                        bbcd_pkg::BBCD_C_JUMP: begin
                            nxt_taken = 1'b1;
                            nxt_tgt   = {op_ff[`BBCD_TGT_HI:`BBCD_TGT_LO], b2_ff};
                        end
                        bbcd_pkg::BBCD_C_SRET: begin
                            nxt_taken = 1'b1;
                            nxt_tgt   = stk_rdata;
                            nxt_sp    = sp_ff - `BBCD_SP_STEP;
                        end
                        bbcd_pkg::BBCD_C_IRET: begin
                            nxt_taken = 1'b1;
                            nxt_tgt   = stk_rdata;
                            nxt_sp    = sp_ff - `BBCD_SP_STEP;
                            nxt_iret  = 1'b1;
                            nxt_we_z  = 1'b1;
                            nxt_we_c  = 1'b1;
                            nxt_z_new = saved_z;
                            nxt_c_new = saved_c;
                        end
                        bbcd_pkg::BBCD_C_HALT: begin
                            nxt_halt = !wdg_sel;
                            nxt_idle = wdg_sel;
                        end
                        bbcd_pkg::BBCD_C_IDLE: begin
                            nxt_idle = 1'b1;
                        end
                        bbcd_pkg::BBCD_C_FOREIGN: begin
                            nxt_foreign = 1'b1;
                        end
                        default: begin
                            nxt_taken = 1'b0;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff   <= bbcd_pkg::BBCD_IDLE;
            cls_ff     <= bbcd_pkg::BBCD_C_NOP;
            cnt_ff     <= `BBCD_CYC_OTHER;
            op_ff      <= `BBCD_BYTE_ZERO;
            b2_ff      <= `BBCD_BYTE_ZERO;
            b3_ff      <= `BBCD_BYTE_ZERO;
            pc_ff      <= `BBCD_PC_RESET;
            data_ff    <= `BBCD_BYTE_ZERO;
            rd_wait_ff <= 1'b0;
            sp_ff      <= `BBCD_SP_RESET;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            foreign_ff <= 1'b0;
            taken_ff   <= 1'b0;
            tgt_ff     <= `BBCD_PC_RESET;
            we_z_ff    <= 1'b0;
            we_c_ff    <= 1'b0;
            z_new_ff   <= 1'b0;
            c_new_ff   <= 1'b0;
            rd_en_ff   <= 1'b0;
            wr_en_ff   <= 1'b0;
            addr_ff    <= `BBCD_BYTE_ZERO;
            wdata_ff   <= `BBCD_BYTE_ZERO;
            halt_ff    <= 1'b0;
            idle_ff    <= 1'b0;
            iret_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cls_ff     <= nxt_cls;
            cnt_ff     <= nxt_cnt;
            op_ff      <= nxt_op;
            b2_ff      <= nxt_b2;
            b3_ff      <= nxt_b3;
            pc_ff      <= nxt_pc;
            data_ff    <= nxt_data;
            rd_wait_ff <= nxt_rd_wait;
            sp_ff      <= nxt_sp;
            busy_ff    <= nxt_busy;
            done_ff    <= nxt_done;
            foreign_ff <= nxt_foreign;
            taken_ff   <= nxt_taken;
            tgt_ff     <= nxt_tgt;
            we_z_ff    <= nxt_we_z;
            we_c_ff    <= nxt_we_c;
            z_new_ff   <= nxt_z_new;
            c_new_ff   <= nxt_c_new;
            rd_en_ff   <= nxt_rd_en;
            wr_en_ff   <= nxt_wr_en;
            addr_ff    <= nxt_addr;
            wdata_ff   <= nxt_wdata;
            halt_ff    <= nxt_halt;
            idle_ff    <= nxt_idle;
            iret_ff    <= nxt_iret;
        end
    end

    assign busy         = busy_ff;
    assign done         = done_ff;
    assign foreign_op   = foreign_ff;
    assign branch_taken = taken_ff;
    assign pc_target    = tgt_ff;
    assign flag_we_z    = we_z_ff;
    assign flag_we_c    = we_c_ff;
    assign flag_z_new   = z_new_ff;
    assign flag_c_new   = c_new_ff;
    assign ds_rd_en     = rd_en_ff;
    assign ds_wr_en     = wr_en_ff;
    assign ds_addr      = addr_ff;
    assign ds_wr_data   = wdata_ff;
    assign halt_req     = halt_ff;
    assign idle_req     = idle_ff;
    assign int_return   = iret_ff;

endmodule : bbcd_decoder

// ===== bbcd_decoder_checker.sv
// Purpose: Timing and result checks on the decoder ports.
// Assumes: Option and saved-flag inputs are judged one cycle before done, as the decoder reads them.
// Notes:   Bound to bbcd_decoder from the testbench.
`timescale 1ns/100ps
module bbcd_decoder_checker (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // Issue
    input wire logic        instr_valid,
    input wire logic [7:0]  instr_opcode,
    input wire logic [7:0]  instr_byte2,
    input wire logic        busy,
    input wire logic        done,
    // Results
    input wire logic        branch_taken,
    input wire logic [11:0] pc_target,
    input wire logic        flag_we_z,
    input wire logic        flag_we_c,
    input wire logic        flag_z_new,
    input wire logic        flag_c_new,
    input wire logic        ds_rd_en,
    input wire logic        ds_wr_en,
    input wire logic [7:0]  ds_addr,
    input wire logic        halt_req,
    input wire logic        idle_req,
    input wire logic        int_return,
    // Core inputs read by the decoder
    input wire logic        saved_z,
    input wire logic        saved_c,
    input wire logic        wdg_sel
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic       iss;
    logic [3:0] lo;
    logic [7:0] op_ff;
    assign iss = instr_valid && !busy;
    assign lo  = instr_opcode[3:0];
    // Holds the opcode of the instruction in flight.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) op_ff <= 8'h00;
        else if (iss) op_ff <= instr_opcode;
    end
    chk_short_len: assert property (iss && !instr_opcode[0] |=> !done ##1 done)
        else $error("short branch length wrong");
    chk_btest_len: assert property (iss && lo == 4'h3 |=> !done [*4] ##1 done)
        else $error("bit test length wrong");
    chk_long_len: assert property (
        iss && (lo == 4'h1 || lo == 4'h9 || lo == 4'hB) |=> !done [*3] ##1 done)
        else $error("long op length wrong");
    chk_ctrl_len: assert property (iss && lo == 4'hD |-> ##2 done)
        else $error("control op length wrong");
    chk_long_target: assert property (
        iss && (lo == 4'h1 || lo == 4'h9) |-> ##4 branch_taken
        && pc_target == {$past(instr_opcode[7:4], 4), $past(instr_byte2, 4)})
        else $error("long target wrong");
    chk_btest_read: assert property (
        iss && lo == 4'h3 |=> ds_rd_en && ds_addr == $past(instr_byte2))
        else $error("bit test read wrong");
    chk_zero_keep: assert property (flag_we_z |-> done && int_return)
        else $error("zero written outside interrupt return");
    chk_bit_carry: assert property (
        done && op_ff[3:0] == 4'h3
        |-> flag_we_c && !flag_we_z && branch_taken == (flag_c_new == op_ff[4]))
        else $error("tested bit not in carry");
    chk_wr_pair: assert property (ds_wr_en |-> done && op_ff[3:0] == 4'hB)
        else $error("write outside bit set or clear");
    chk_halt_wdg: assert property (
        done && op_ff == 8'h6D
        |-> halt_req != $past(wdg_sel) && idle_req == $past(wdg_sel))
        else $error("halt not swapped for idle");
    chk_iret_flags: assert property (
        int_return
        |-> flag_we_c && flag_z_new == $past(saved_z) && flag_c_new == $past(saved_c))
        else $error("interrupt return flags wrong");
endmodule : bbcd_decoder_checker

// ===== testbench.sv
// Purpose: Directed tests of the branch, bit and control decoder.
// Assumes: Data space read data is held steady through each instruction.
// Notes:   Each scenario issues one instruction at a time and waits for done.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: mismatch on line %0d", $time, `__LINE__); end end
module testbench;
    logic        clk_sys = 0, arst_n = 0, instr_valid = 0, flag_z = 0, flag_c = 0;
    logic        saved_z = 0, saved_c = 0, wdg_sel = 0;
    logic [7:0]  instr_opcode = 0, instr_byte2 = 0, instr_byte3 = 0, ds_rd_data = 8'hA5;
    logic [11:0] instr_pc = 0, pc_target;
    logic        busy, done, foreign_op, branch_taken, flag_we_z, flag_we_c, flag_z_new;
    logic        flag_c_new, ds_rd_en, ds_wr_en, halt_req, idle_req, int_return;
    logic [7:0]  ds_addr, ds_wr_data;
    int          mismatches = 0, check_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    bbcd_decoder u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .instr_valid(instr_valid),
        .instr_opcode(instr_opcode), .instr_byte2(instr_byte2), .instr_byte3(instr_byte3),
        .instr_pc(instr_pc), .busy(busy), .done(done), .foreign_op(foreign_op),
        .branch_taken(branch_taken), .pc_target(pc_target), .flag_z(flag_z), .flag_c(flag_c),
        .saved_z(saved_z), .saved_c(saved_c), .wdg_sel(wdg_sel), .flag_we_z(flag_we_z),
        .flag_we_c(flag_we_c), .flag_z_new(flag_z_new), .flag_c_new(flag_c_new),
        .ds_rd_en(ds_rd_en), .ds_wr_en(ds_wr_en), .ds_addr(ds_addr), .ds_wr_data(ds_wr_data),
        .ds_rd_data(ds_rd_data), .halt_req(halt_req), .idle_req(idle_req),
        .int_return(int_return));
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // Issues one instruction and returns in its done cycle, checking the cycle count.
    task automatic run(input logic [7:0] op, b2, b3, input logic [11:0] pc, input int n);
        int k;
        instr_opcode = op;
        instr_byte2 = b2;
        instr_byte3 = b3;
        instr_pc = pc;
        instr_valid = 1;
        @(posedge clk_sys);
        #1 instr_valid = 0;
        k = 1;
        while (done !== 1'b1 && k < 9) begin
            @(posedge clk_sys);
            #1 k++;
        end
        if (done !== 1'b1) begin
            mismatches++;
            conclude();
        end
        `CHK(k, n)
    endtask : run
    task automatic t_short;
        logic e;
        for (int t = 0; t < 4; t++) for (int f = 0; f < 2; f++) begin
            flag_z = f[0];
            flag_c = !f[0];
            e = f[0] ^ (t[0] == t[1]);
            run({4'hF, 1'b0, t[1:0], 1'b0}, 8'h00, 8'h00, 12'h100, 2);
            `CHK({branch_taken, flag_we_z, flag_we_c}, {e, 2'b00})
            `CHK(pc_target, e ? 12'h110 : 12'h101)
            run({4'hF, 1'b1, t[1:0], 1'b0}, 8'h00, 8'h00, 12'h100, 2);
            `CHK(pc_target, e ? 12'h0F1 : 12'h101)
        end
        $display("short branch test done");
    endtask : t_short
    task automatic t_btest;
        logic bv;
        for (int i = 0; i < 16; i++) begin
            bv = ds_rd_data[i[2:0]];
            run({i[0], i[1], i[2], i[3], 4'h3}, 8'h42,
                i[3] ? 8'h80 : 8'h7F, 12'h200, 5);
            `CHK({ds_addr, flag_we_z, flag_we_c, flag_c_new}, {8'h42, 2'b01, bv})
            `CHK(pc_target, bv == i[3] ? (i[3] ? 12'h182 : 12'h281) : 12'h203)
        end
        $display("bit test branch test done");
    endtask : t_btest
    task automatic t_bmod;
        logic [7:0] e;
        for (int i = 0; i < 16; i++) begin
            e = i[3] ? (8'hA5 | (8'h01 << i[2:0])) : (8'hA5 & ~(8'h01 << i[2:0]));
            run({i[0], i[1], i[2], i[3], 4'hB}, 8'h37, 8'h00, 12'h300, 4);
            `CHK({ds_wr_en, ds_addr, ds_wr_data}, {1'b1, 8'h37, e})
            `CHK({flag_we_z, flag_we_c}, 2'b00)
        end
        $display("bit set and clear test done");
    endtask : t_bmod
    task automatic t_flow;
        run(8'hA9, 8'h5C, 8'h00, 12'h010, 4);
        `CHK({branch_taken, pc_target, flag_we_z, flag_we_c}, {1'b1, 12'hA5C, 2'b00})
        run(8'h31, 8'h20, 8'h00, 12'h400, 4);
        `CHK(pc_target, 12'h320)
        run(8'hC1, 8'h88, 8'h00, 12'h320, 4);
        `CHK(pc_target, 12'hC88)
        run(8'hCD, 8'h00, 8'h00, 12'hC88, 2);
        `CHK({branch_taken, pc_target, flag_we_z, flag_we_c}, {1'b1, 12'h322, 2'b00})
        saved_z = 1;
        saved_c = 0;
        run(8'hDD, 8'h00, 8'h00, 12'h322, 2);
        `CHK({int_return, pc_target}, {1'b1, 12'h402})
        `CHK({flag_we_z, flag_we_c, flag_z_new, flag_c_new}, 4'hE)
        $display("jump, call and return test done");
    endtask : t_flow
    task automatic t_ctrl;
        logic [7:0] ops [5] = '{8'h0D, 8'h6D, 8'h6D, 8'hED, 8'h05};
        logic [3:0] exp [5] = '{4'h0, 4'h8, 4'h4, 4'h4, 4'h2};
        for (int i = 0; i < 5; i++) begin
            wdg_sel = (i == 2);
            run(ops[i], 8'h00, 8'h00, 12'h050, 2);
            `CHK({halt_req, idle_req, foreign_op, branch_taken}, exp[i])
            if (i < 4) `CHK({pc_target, flag_we_z, flag_we_c}, {12'h051, 2'b00})
        end
        wdg_sel = 0;
        $display("control test done");
    endtask : t_ctrl
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 arst_n = 1;
        `CHK({busy, done, pc_target}, 14'h0000)
        t_short();
        t_btest();
        t_bmod();
        t_flow();
        t_ctrl();
        conclude();
    end
endmodule : testbench
bind bbcd_decoder bbcd_decoder_checker u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr_opcode(instr_opcode), .instr_byte2(instr_byte2),
    .busy(busy), .done(done), .branch_taken(branch_taken), .pc_target(pc_target),
    .flag_we_z(flag_we_z), .flag_we_c(flag_we_c), .flag_z_new(flag_z_new),
    .flag_c_new(flag_c_new), .ds_rd_en(ds_rd_en), .ds_wr_en(ds_wr_en), .ds_addr(ds_addr),
    .halt_req(halt_req), .idle_req(idle_req), .int_return(int_return), .saved_z(saved_z),
    .saved_c(saved_c), .wdg_sel(wdg_sel));
